// *** ghio_rail_regs.sv ***
/*
  configuration register bank for the gate-high boost targets and the io rails.
  assumes a simple strobe bus synchronous to clk_i, read data one cycle later.
*/
// Local design decision: the address-and-strobe port.
// Operation
// RULE1: offset 0x02 low four bits hold hot gate-high target.
// RULE2: hot code maps 16 V to 31 V in 1 V steps.
// RULE3: offset 0x03 low four bits hold cold gate-high target.
// RULE4: cold code maps 25 V to 40 V in 1 V steps.
// RULE5: unused upper bits drop writes and read zero.
// RULE6: offset 0x04 low two bits select buck and regulator outputs.
// RULE7: io code decodes into fixed buck and regulator voltages.
// RULE8: host writes io setting only after enable and power-up complete.
// RULE9: registers are eight bits, reads return field with zeros above.
`default_nettype none
`include "ghio_defines.svh"
module ghio_rail_regs (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  // register bus
  input  wire logic [`GHIO_ADDR_W-1:0]      addr_i,
  input  wire logic [`GHIO_DATA_W-1:0]      wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [`GHIO_DATA_W-1:0]      rdata_o,
  // hot or cold select from temperature logic
  input  wire logic                         temp_cold_i,
  // rail targets
  output logic      [3:0]                   gh_hot_code_o,
  output logic      [3:0]                   gh_cold_code_o,
  output logic      [5:0]                   gate_high_rail_v_o,
  output logic      [1:0]                   io_rail_code_o,
  output ghio_pkg::ghio_io_target_s         io_target_o
);
  import ghio_pkg::*;

  logic [`GHIO_GH_FIELD_W-1:0] gh_hot_reg;
  logic [`GHIO_GH_FIELD_W-1:0] gh_cold_reg;
  logic [`GHIO_IO_FIELD_W-1:0] io_rail_reg;
  logic [`GHIO_DATA_W-1:0]     rdata_reg;
  logic [`GHIO_DATA_W-1:0]     rdata_next;

  // address decode
  wire sel_hot  = (addr_i == `GHIO_OFF_GH_HOT);   // [RULE1]
  wire sel_cold = (addr_i == `GHIO_OFF_GH_COLD);  // [RULE3]
  wire sel_io   = (addr_i == `GHIO_OFF_IO_RAIL);  // [RULE6]

  // per-register write strobes; unmapped offsets match none of them
  wire wr_hot  = wr_i && sel_hot;              // [RULE1]
  wire wr_cold = wr_i && sel_cold;             // [RULE3]
  wire wr_io   = wr_i && sel_io;               // [RULE6]
  wire sel_any = sel_hot || sel_cold || sel_io;

  // hot target keeps only the implemented low bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gh_hot_reg <= `GHIO_GH_HOT_RESET;
    end else if (wr_hot) begin
      gh_hot_reg <= wdata_i[`GHIO_GH_FIELD_W-1:0]; // [RULE1] [RULE5]
    end
  end

  // cold target keeps only the implemented low bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gh_cold_reg <= `GHIO_GH_COLD_RESET;
    end else if (wr_cold) begin
      gh_cold_reg <= wdata_i[`GHIO_GH_FIELD_W-1:0]; // [RULE3] [RULE5]
    end
  end

  // io rail code keeps only its two low bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_rail_reg <= `GHIO_IO_RAIL_RESET;
    end else if (wr_io) begin
      io_rail_reg <= wdata_i[`GHIO_IO_FIELD_W-1:0]; // [RULE6] [RULE5]
    end
  end

  // padded read images, zero above each field
  wire [`GHIO_DATA_W-1:0] hot_img  = {{(`GHIO_DATA_W-`GHIO_GH_FIELD_W){1'b0}}, gh_hot_reg};  // [RULE5]
  wire [`GHIO_DATA_W-1:0] cold_img = {{(`GHIO_DATA_W-`GHIO_GH_FIELD_W){1'b0}}, gh_cold_reg}; // [RULE5]
  wire [`GHIO_DATA_W-1:0] io_img   = {{(`GHIO_DATA_W-`GHIO_IO_FIELD_W){1'b0}}, io_rail_reg}; // [RULE5]

  // read mux, zero for unmapped offsets
  assign rdata_next = sel_hot  ? hot_img  :
                      sel_cold ? cold_img :
                      sel_io   ? io_img   : `GHIO_RDATA_IDLE; // [RULE5] [RULE9]

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= `GHIO_RDATA_IDLE;
    end else begin
      rdata_reg <= rd_i ? rdata_next : `GHIO_RDATA_IDLE; // [RULE9]
    end
  end
  assign rdata_o = rdata_reg;

  // gate-high target in volts, base plus code
  wire [5:0] hot_v  = `GHIO_GH_HOT_BASE_V + {2'h0, gh_hot_reg};   // [RULE2]
  wire [5:0] cold_v = `GHIO_GH_COLD_BASE_V + {2'h0, gh_cold_reg}; // [RULE4]
  assign gate_high_rail_v_o = temp_cold_i ? cold_v : hot_v;
  assign gh_hot_code_o      = gh_hot_reg;
  assign gh_cold_code_o     = gh_cold_reg;
  // io rail writes are assumed to follow enable and power-up [RULE8]
  assign io_rail_code_o     = io_rail_reg;

  ghio_io_decode u_decode (
    .code_i   (io_rail_reg),
    .target_o (io_target_o)
  );

  // checks
  property p_hot_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_i && sel_hot) |=> (gh_hot_code_o == $past(wdata_i[3:0]));
  endproperty
  a_hot_write: assert property (p_hot_write) else $error("hot write lost"); // [RULE1]

  property p_cold_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_i && sel_cold) |=> (gh_cold_code_o == $past(wdata_i[3:0]));
  endproperty
  a_cold_write: assert property (p_cold_write) else $error("cold write lost"); // [RULE3]

  property p_io_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_i && sel_io) |=> (io_rail_code_o == $past(wdata_i[1:0]));
  endproperty
  a_io_write: assert property (p_io_write) else $error("io write lost"); // [RULE6]

  property p_hot_volts;
    @(posedge clk_i) disable iff (!reset_n_i)
    !temp_cold_i |-> (gate_high_rail_v_o == 6'd16 + {2'h0, gh_hot_code_o});
  endproperty
  a_hot_volts: assert property (p_hot_volts) else $error("hot volts wrong"); // [RULE2]

  property p_cold_volts;
    @(posedge clk_i) disable iff (!reset_n_i)
    temp_cold_i |-> (gate_high_rail_v_o == 6'd25 + {2'h0, gh_cold_code_o});
  endproperty
  a_cold_volts: assert property (p_cold_volts) else $error("cold volts wrong"); // [RULE4]

  property p_upper_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && (sel_hot || sel_cold)) |=> (rdata_o[7:4] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set"); // [RULE5]

  property p_read_back;
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && sel_io) |=> (rdata_o == {6'h00, $past(io_rail_reg)});
  endproperty
  a_read_back: assert property (p_read_back) else $error("io read wrong"); // [RULE9]

  property p_io_decode;
    @(posedge clk_i) disable iff (!reset_n_i)
    (io_rail_code_o == 2'h3) |-> (io_target_o.rail_one_mv == 12'd2500 && io_target_o.rail_two_mv == 12'd1800);
  endproperty
  a_io_decode: assert property (p_io_decode) else $error("io decode wrong"); // [RULE7]

  property p_io_off;
    @(posedge clk_i) disable iff (!reset_n_i)
    (io_rail_code_o[1] == 1'b0) |-> !io_target_o.rail_two_en;
  endproperty
  a_io_off: assert property (p_io_off) else $error("regulator on"); // [RULE7]

  // read-back, hold and decode checks
  property p_hot_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && sel_hot) |=> (rdata_o == {4'h0, $past(gh_hot_code_o)});
  endproperty
  a_hot_read: assert property (p_hot_read) else $error("hot read wrong"); // [RULE1] [RULE9]

  property p_cold_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && sel_cold) |=> (rdata_o == {4'h0, $past(gh_cold_code_o)});
  endproperty
  a_cold_read: assert property (p_cold_read) else $error("cold read wrong"); // [RULE3] [RULE9]

  property p_unmapped_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && !sel_any) |=> (rdata_o == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [RULE5]

  property p_rd_idle;
    @(posedge clk_i) disable iff (!reset_n_i)
    !rd_i |=> (rdata_o == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle"); // [RULE9]

  property p_hot_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    !wr_hot |=> $stable(gh_hot_code_o);
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("hot code changed without write"); // [RULE1]

  property p_cold_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    !wr_cold |=> $stable(gh_cold_code_o);
  endproperty
  a_cold_hold: assert property (p_cold_hold) else $error("cold code changed without write"); // [RULE3]

  property p_io_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    !wr_io |=> $stable(io_rail_code_o);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("io code changed without write"); // [RULE6]

  property p_io_code0;
    @(posedge clk_i) disable iff (!reset_n_i)
    (io_rail_code_o == 2'h0) |-> (io_target_o.rail_one_mv == 12'd1700 && !io_target_o.rail_two_en);
  endproperty
  a_io_code0: assert property (p_io_code0) else $error("io code 0 decode wrong"); // [RULE7]

  property p_io_code1;
    @(posedge clk_i) disable iff (!reset_n_i)
    (io_rail_code_o == 2'h1) |-> (io_target_o.rail_one_mv == 12'd1800 && !io_target_o.rail_two_en);
  endproperty
  a_io_code1: assert property (p_io_code1) else $error("io code 1 decode wrong"); // [RULE7]

  property p_io_code2;
    @(posedge clk_i) disable iff (!reset_n_i)
    (io_rail_code_o == 2'h2) |-> (io_target_o.rail_one_mv == 12'd2500 && io_target_o.rail_two_mv == 12'd1700);
  endproperty
  a_io_code2: assert property (p_io_code2) else $error("io code 2 decode wrong"); // [RULE7]

  c_hot_wr:  cover property (@(posedge clk_i) disable iff (!reset_n_i) wr_i && sel_hot);
  c_cold_rd: cover property (@(posedge clk_i) disable iff (!reset_n_i) rd_i && sel_cold);
  c_io_max:  cover property (@(posedge clk_i) disable iff (!reset_n_i) io_rail_code_o == 2'h3);
  c_wr_rd:   cover property (@(posedge clk_i) disable iff (!reset_n_i) (wr_i && sel_io) ##1 (rd_i && sel_io));
  c_cold_max: cover property (@(posedge clk_i) disable iff (!reset_n_i) temp_cold_i && gate_high_rail_v_o == 6'd40);
endmodule : ghio_rail_regs
`default_nettype wire

// *** ghio_defines.svh ***
/*
  constants for the gate-high and io rail configuration bank.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef GHIO_DEFINES_SVH
`define GHIO_DEFINES_SVH
`define GHIO_ADDR_W          8
`define GHIO_DATA_W          8
`define GHIO_OFF_GH_HOT      8'h02
`define GHIO_OFF_GH_COLD     8'h03
`define GHIO_OFF_IO_RAIL     8'h04
`define GHIO_GH_FIELD_W      4
`define GHIO_IO_FIELD_W      2
`define GHIO_GH_HOT_RESET    4'h0
`define GHIO_GH_COLD_RESET   4'h0
`define GHIO_IO_RAIL_RESET   2'h0
`define GHIO_RDATA_IDLE      8'h00
`define GHIO_GH_HOT_BASE_V   6'h10
`define GHIO_GH_COLD_BASE_V  6'h19
`define GHIO_MV_1V7          12'h6a4
`define GHIO_MV_1V8          12'h708
`define GHIO_MV_2V5          12'h9c4
`define GHIO_MV_OFF          12'h000
`endif

// *** ghio_pkg.sv ***
/*
  types shared by the rail configuration bank and its decoder.
  assumes ghio_defines.svh is on the include path.
*/
`default_nettype none
`include "ghio_defines.svh"
package ghio_pkg;
  // decoded io rail targets in millivolts, regulator enable
  typedef struct packed {
    logic [11:0] rail_one_mv;
    logic [11:0] rail_two_mv;
    logic        rail_two_en;
  } ghio_io_target_s;
endpackage : ghio_pkg
`default_nettype wire

// *** ghio_io_decode.sv ***
/*
  decodes the two-bit io rail code into rail targets.
  assumes a stable registered code at its input.
*/
`default_nettype none
`include "ghio_defines.svh"
module ghio_io_decode (
  // code in
  input  wire logic [1:0]                code_i,
  // decoded targets
  output ghio_pkg::ghio_io_target_s      target_o
);
  import ghio_pkg::*;
  // fixed four-entry map of buck and regulator targets
  wire [11:0] one_mv = (code_i == 2'h0) ? `GHIO_MV_1V7 :
                       (code_i == 2'h1) ? `GHIO_MV_1V8 : `GHIO_MV_2V5; // [RULE7]
  wire [11:0] two_mv = (code_i == 2'h2) ? `GHIO_MV_1V7 :
                       (code_i == 2'h3) ? `GHIO_MV_1V8 : `GHIO_MV_OFF; // [RULE7]
  wire        two_en = code_i[1];                                      // regulator on for codes 2 and 3 [RULE7]
  // one driver for the whole struct, members packed in declaration order
  assign target_o = {one_mv, two_mv, two_en};
endmodule : ghio_io_decode
`default_nettype wire

// *** tb.sv ***
/*
  self-checking bench for the rail configuration bank: random and corner accesses.
  assumes ghio_pkg and ghio_rail_regs are compiled first; clk_i at 200 MHz.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ghio_pkg::*;
  logic            clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, temp_cold_i = 0;
  logic [7:0]      addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [3:0]      gh_hot_code_o, gh_cold_code_o;
  logic [5:0]      gate_high_rail_v_o;
  logic [1:0]      io_rail_code_o;
  ghio_io_target_s io_target_o;
  int              n_mismatch = 0, comparisons = 0, cycles = 0;
  logic [15:0]     lfsr = 16'd1702;
  logic [7:0]      sh [0:255] = '{default: 8'h00};
  ghio_rail_regs dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .temp_cold_i(temp_cold_i), .gh_hot_code_o(gh_hot_code_o),
    .gh_cold_code_o(gh_cold_code_o), .gate_high_rail_v_o(gate_high_rail_v_o),
    .io_rail_code_o(io_rail_code_o), .io_target_o(io_target_o));
  // clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  // stored image of a write: upper bits dropped, unmapped gone
  function automatic logic [7:0] msk(input logic [7:0] a, input logic [7:0] d);
    return (a == 8'h02 || a == 8'h03) ? {4'h0, d[3:0]} : (a == 8'h04) ? {6'h00, d[1:0]} : 8'h00;
  endfunction : msk
  function automatic ghio_io_target_s iot(input logic [1:0] c);
    case (c)
      2'h0: return '{12'h6a4, 12'h000, 1'b0};
      2'h1: return '{12'h708, 12'h000, 1'b0};
      2'h2: return '{12'h9c4, 12'h6a4, 1'b1};
      default: return '{12'h9c4, 12'h708, 1'b1};
    endcase
  endfunction : iot
  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic outs();
    chk(gh_hot_code_o, sh[2][3:0], "hot code");
    chk(gh_cold_code_o, sh[3][3:0], "cold code");
    chk(gate_high_rail_v_o, temp_cold_i ? 6'd25 + sh[3][3:0] : 6'd16 + sh[2][3:0], "rail volts");
    chk(io_rail_code_o, sh[4][1:0], "io code");
    chk(io_target_o, iot(sh[4][1:0]), "io target");
  endtask : outs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    temp_cold_i <= rnd() > 8'h7f;
    @(posedge clk_i);
    wr_i <= 1'b0;
    sh[a] = msk(a, d);
    #1 outs();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, sh[a], "read data");
    @(posedge clk_i);
    #1 chk(rdata_o, 8'h00, "read data idle");
  endtask : rd
  // write then read the same offset with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    sh[a] = msk(a, d);
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, sh[a], "read after write");
    outs();
    @(posedge clk_i);
    #1 chk(rdata_o, 8'h00, "read after write idle");
  endtask : wr_rd
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    logic [7:0] a;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1 outs();
    for (int i = 2; i < 5; i++) rd(8'(i));
    $display("test reset done");
    wr(8'h02, 8'ha5);
    rd(8'h02);
    wr_rd(8'h03, 8'h3c);
    foreach (sh[i]) if (i < 2) begin
      wr(8'h02, {4'hf, {4{i[0]}}});
      wr(8'h03, {4'ha, {4{i[0]}}});
      rd(8'h03);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 8'hfc | 8'(c));
      rd(8'h04);
      wr_rd(8'h04, 8'(3 - c));
    end
    $display("test corners done");
    for (int n = 0; n < 80; n++) begin
      a = rnd();
      if (a[7:6] != 2'b00) a = 8'h02 + 8'(a[1:0] % 3);
      if (rnd() > 8'h60) wr(a, rnd());
      else rd(a);
    end
    $display("test random done");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    sh = '{default: 8'h00};
    #1 outs();
    chk(rdata_o, 8'h00, "read data in reset");
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'h04);
    $display("test second reset done");
    conclude();
  end
endmodule : tb
`default_nettype wire
